// >>> core/modem_pin_sync.v
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes pins are asynchronous to aclk; reset value is a constant parameter.
`timescale 1ns/10ps
module modem_pin_sync #(
  parameter WIDTH = 5,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out
);
  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;
  reg [WIDTH-1:0] stage3_ff;
  reg [WIDTH-1:0] stable_ff;
  reg [WIDTH-1:0] nxt_stable;
  integer i;

  // Accept a bit only when stages two and three agree
  always @* begin
    nxt_stable = stable_ff;
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (stage2_ff[i] == stage3_ff[i]) begin
        nxt_stable[i] = stage3_ff[i];
      end
    end
  end

  // Shift chain; first stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
      stage3_ff <= RESET_VAL;
      stable_ff <= RESET_VAL;
    end else if (clk_en) begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      stable_ff <= nxt_stable;
    end
  end

  assign pin_out = stable_ff;
endmodule // modem_pin_sync

// >>> core/uart_modem_control.v
// Modem control of a UART: handshake outputs, loopback, auto flow gating.
// Assumes FIFO enable, trigger level and fill count come from the UART on aclk.
`timescale 1ns/10ps
`include "uart_modem_map.vh"

// Notes on behaviour
// (R1) Infrared mode bit enables infrared encoding; writes need the write-enable key bit.
// (R2) Auto flow control runs while the auto flow enable bit is one.
// (R3) Loopback without infrared holds serial out high, loops transmit into receive.
// (R4) Interrupt sources keep working in loopback; nothing gates them here.
// (R5) Loopback ignores the four modem status pins and feeds outputs back.
// (R6) Second user output pin is the inverse of its bit.
// (R7) First user output pin is the inverse of its bit.
// (R8) Loopback holds all four handshake output pins inactive high.
// (R9) Without auto flow, request-to-send pin is the inverse of its bit.
// (R10) Auto flow with FIFOs on gates request-to-send above trigger level.
// (R11) Flow-trigger option gates instead on almost full, two free slots.
// (R12) Terminal-ready pin is the inverse of its bit.
// (R13) Trigger field picks one char, quarter, half or two below full.
// (R14) Auto flow gating applies only while FIFO enable is set.
// (R15) Loopback maps ready to data-set-ready, send to clear, outputs to ring, carrier.
// (R16) Reserved bits above bit six read zero and ignore writes.
module uart_modem_control #(
  parameter ADDR_W = 8,
  parameter FIFO_DEPTH = 16,
  parameter CNT_W = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire [ADDR_W-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  input wire [ADDR_W-1:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  input wire fifo_enable,
  input wire [1:0] receive_trigger_level,
  input wire [CNT_W-1:0] rx_fifo_count,
  input wire tx_serial_data,
  output wire rx_serial_data,
  output wire ir_mode_enable,
  output wire auto_flow_active,
  output wire loopback_active,
  input wire serial_in,
  output wire serial_out,
  output wire terminal_ready_low,
  output wire request_to_send_low,
  output wire user_output_one_low,
  output wire user_output_two_low,
  input wire clear_to_send_low_in,
  input wire data_set_ready_low_in,
  input wire ring_indicator_low_in,
  input wire carrier_detect_low_in,
  output wire clear_to_send_status_low,
  output wire data_set_ready_status_low,
  output wire ring_indicator_status_low,
  output wire carrier_detect_status_low
);
  localparam integer QUARTER_INT = FIFO_DEPTH / 4;
  localparam integer HALF_INT = FIFO_DEPTH / 2;
  localparam integer ALMOST_INT = FIFO_DEPTH - `ALMOST_FULL_FREE;
  localparam [CNT_W-1:0] THR_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] THR_QUARTER = QUARTER_INT[CNT_W-1:0];
  localparam [CNT_W-1:0] THR_HALF = HALF_INT[CNT_W-1:0];
  localparam [CNT_W-1:0] THR_ALMOST = ALMOST_INT[CNT_W-1:0];

  // Trigger level to fill threshold
  function [CNT_W-1:0] rx_threshold;
    input [1:0] lvl;
    begin
      case (lvl)
        `TRIG_ONE_CHAR: rx_threshold = THR_ONE;
        `TRIG_QUARTER: rx_threshold = THR_QUARTER;
        `TRIG_HALF: rx_threshold = THR_HALF;
        default: rx_threshold = THR_ALMOST;
      endcase
    end
  endfunction

  // Register offset match on a word-aligned address
  function addr_is;
    input [ADDR_W-1:0] addr;
    input [7:0] ofs;
    begin
      addr_is = ({addr[ADDR_W-1:2], 2'b00} == ofs);
    end
  endfunction

  reg aw_held_ff;
  reg [ADDR_W-1:0] awaddr_ff;
  reg w_held_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [`MLC_WIDTH-1:0] mlc_ff;
  reg [`MLC_WIDTH-1:0] nxt_mlc;
  reg [`FCFG_WIDTH-1:0] fcfg_ff;
  reg [`FCFG_WIDTH-1:0] nxt_fcfg;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;
  reg [1:0] nxt_bresp;
  reg dtr_low_ff;
  reg rts_low_ff;
  reg out1_low_ff;
  reg out2_low_ff;
  reg sout_ff;
  reg rx_data_ff;
  reg [3:0] status_low_ff;
  reg [3:0] nxt_status_low;
  wire [4:0] pins_synced;
  wire do_write;
  wire do_read;
  wire loop_on;
  wire serial_loop;
  wire afc_on;
  wire flow_trig;
  wire rx_above;
  wire rts_gated;
  wire rts_drive;
  wire [`MST_WIDTH-1:0] modem_state;

  // Modem status pins and serial input cross into aclk
  modem_pin_sync #(
    .WIDTH(5),
    .RESET_VAL(5'h1f)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .pin_in({serial_in, carrier_detect_low_in, ring_indicator_low_in,
             data_set_ready_low_in, clear_to_send_low_in}),
    .pin_out(pins_synced)
  );

  // Mode decode
  assign loop_on = mlc_ff[`MLC_LOOPBACK];
  assign serial_loop = loop_on & ~mlc_ff[`MLC_IR_MODE]; // R3
  assign afc_on = mlc_ff[`MLC_AUTO_FLOW]; // R2
  assign flow_trig = fcfg_ff[`FCFG_FLOW_TRIGGER];

  // Receive fill compare for flow gating
  assign rx_above = flow_trig ? (rx_fifo_count > THR_ALMOST) // R11
                              : (rx_fifo_count > rx_threshold(receive_trigger_level)); // R10 R13
  assign rts_gated = afc_on & fifo_enable & rx_above; // R10 R14
  assign rts_drive = mlc_ff[`MLC_SEND_REQ] & ~rts_gated; // R9

  // Readable block state
  assign modem_state = {~rts_low_ff, rts_gated, serial_loop,
                        ~status_low_ff[3], ~status_low_ff[2],
                        ~status_low_ff[1], ~status_low_ff[0]};

  // Bus handshakes
  assign awready = ~aw_held_ff & ~bvalid_ff;
  assign wready = ~w_held_ff & ~bvalid_ff;
  assign arready = ~rvalid_ff;
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign do_read = arvalid & ~rvalid_ff;

  // Write decode with byte lane zero
  always @* begin
    nxt_mlc = mlc_ff;
    nxt_fcfg = fcfg_ff;
    nxt_bresp = `RESP_OKAY;
    if (addr_is(awaddr_ff, `MODEM_LINE_CONTROL_OFS)) begin
      if (wstrb_ff[0]) begin
        nxt_mlc[5:0] = wdata_ff[5:0]; // R16
        if (fcfg_ff[`FCFG_IR_WRITE_ENABLE]) begin
          nxt_mlc[`MLC_IR_MODE] = wdata_ff[`MLC_IR_MODE]; // R1
        end
      end
    end else if (addr_is(awaddr_ff, `FLOW_CONFIG_OFS)) begin
      if (wstrb_ff[0]) begin
        nxt_fcfg = wdata_ff[`FCFG_WIDTH-1:0];
      end
    end else if (!addr_is(awaddr_ff, `MODEM_STATE_OFS)) begin
      nxt_bresp = `RESP_SLVERR;
    end
  end

  // Read decode; unused bits read zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `RESP_OKAY;
    if (addr_is(araddr, `MODEM_LINE_CONTROL_OFS)) begin
      nxt_rdata[`MLC_WIDTH-1:0] = mlc_ff; // R16
    end else if (addr_is(araddr, `MODEM_STATE_OFS)) begin
      nxt_rdata[`MST_WIDTH-1:0] = modem_state;
    end else if (addr_is(araddr, `FLOW_CONFIG_OFS)) begin
      nxt_rdata[`FCFG_WIDTH-1:0] = fcfg_ff;
    end else begin
      nxt_rresp = `RESP_SLVERR;
    end
  end

  // Write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= {ADDR_W{1'b0}};
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      mlc_ff <= `MLC_RESET;
      fcfg_ff <= `FCFG_RESET;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= nxt_bresp;
        mlc_ff <= nxt_mlc;
        fcfg_ff <= nxt_fcfg;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `RESP_OKAY;
    end else if (clk_en) begin
      if (do_read) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rresp;
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Status seen by the UART: pins, or outputs looped back
  always @* begin
    if (loop_on) begin
      nxt_status_low[0] = ~mlc_ff[`MLC_SEND_REQ]; // R5 R15
      nxt_status_low[1] = ~mlc_ff[`MLC_TERM_READY]; // R15
      nxt_status_low[2] = ~mlc_ff[`MLC_USER_OUT_ONE]; // R15
      nxt_status_low[3] = ~mlc_ff[`MLC_USER_OUT_TWO]; // R15
    end else begin
      nxt_status_low = pins_synced[3:0];
    end
  end

  // Handshake pins and serial paths
  always @(posedge aclk) begin
    if (!aresetn) begin
      dtr_low_ff <= 1'b1;
      rts_low_ff <= 1'b1;
      out1_low_ff <= 1'b1;
      out2_low_ff <= 1'b1;
      sout_ff <= 1'b1;
      rx_data_ff <= 1'b1;
      status_low_ff <= 4'hf;
    end else if (clk_en) begin
      if (loop_on) begin
        dtr_low_ff <= 1'b1; // R8
        rts_low_ff <= 1'b1; // R8
        out1_low_ff <= 1'b1; // R8
        out2_low_ff <= 1'b1; // R8
      end else begin
        dtr_low_ff <= ~mlc_ff[`MLC_TERM_READY]; // R12
        rts_low_ff <= ~rts_drive; // R9 R10 R11
        out1_low_ff <= ~mlc_ff[`MLC_USER_OUT_ONE]; // R7
        out2_low_ff <= ~mlc_ff[`MLC_USER_OUT_TWO]; // R6
      end
      if (serial_loop) begin
        sout_ff <= 1'b1; // R3
        rx_data_ff <= tx_serial_data; // R3 R4
      end else begin
        sout_ff <= tx_serial_data;
        rx_data_ff <= pins_synced[4];
      end
      status_low_ff <= nxt_status_low; // R5
    end
  end

  // Bus outputs
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // Mode outputs toward the rest of the UART
  assign ir_mode_enable = mlc_ff[`MLC_IR_MODE]; // R1
  assign auto_flow_active = afc_on; // R2
  assign loopback_active = loop_on;

  // Pin outputs
  assign serial_out = sout_ff;
  assign rx_serial_data = rx_data_ff;
  assign terminal_ready_low = dtr_low_ff;
  assign request_to_send_low = rts_low_ff;
  assign user_output_one_low = out1_low_ff;
  assign user_output_two_low = out2_low_ff;
  assign clear_to_send_status_low = status_low_ff[0];
  assign data_set_ready_status_low = status_low_ff[1];
  assign ring_indicator_status_low = status_low_ff[2];
  assign carrier_detect_status_low = status_low_ff[3];
endmodule // uart_modem_control

// >>> core/uart_modem_map.vh
// Register offsets, field positions and reset values of the modem control block.
// Assumes inclusion by plain name from the core/ design files.
`ifndef UART_MODEM_MAP_VH
`define UART_MODEM_MAP_VH

// Byte offsets on the register bus
`define MODEM_LINE_CONTROL_OFS 8'h10
`define MODEM_STATE_OFS 8'h18
`define FLOW_CONFIG_OFS 8'h40

// Fields of modem_line_control
`define MLC_TERM_READY 0
`define MLC_SEND_REQ 1
`define MLC_USER_OUT_ONE 2
`define MLC_USER_OUT_TWO 3
`define MLC_LOOPBACK 4
`define MLC_AUTO_FLOW 5
`define MLC_IR_MODE 6
`define MLC_WIDTH 7
`define MLC_RESET 7'h00

// Fields of flow_config
`define FCFG_FLOW_TRIGGER 0
`define FCFG_IR_WRITE_ENABLE 1
`define FCFG_WIDTH 2
`define FCFG_RESET 2'h0

// Fields of modem_state (read only, active high)
`define MST_CTS 0
`define MST_DSR 1
`define MST_RI 2
`define MST_DCD 3
`define MST_LOOP_SERIAL 4
`define MST_RTS_GATED 5
`define MST_RTS_LOW 6
`define MST_WIDTH 7

// Receive trigger level encodings
`define TRIG_ONE_CHAR 2'h0
`define TRIG_QUARTER 2'h1
`define TRIG_HALF 2'h2
`define TRIG_TWO_LESS 2'h3

// Free slots that count as almost full
`define ALMOST_FULL_FREE 2

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> test/modem_partner.sv
// Modem side model: echoes ready and send lines and the serial line, bench sets ring, carrier.
// Assumes the bench gives the echo delay as 0 to 15, for an echo 1 to 16 clock cycles later.
`timescale 1ns/10ps
module modem_partner (
  input wire aclk,
  input wire [3:0] delay,
  input wire terminal_ready_low,
  input wire request_to_send_low,
  input wire [1:0] ring_carrier_low,
  input wire serial_out,
  output wire clear_to_send_low_in,
  output wire data_set_ready_low_in,
  output wire ring_indicator_low_in,
  output wire carrier_detect_low_in,
  output wire serial_in
);
  logic [15:0] cts_pipe = 16'hffff;
  logic [15:0] dsr_pipe = 16'hffff;
  // Echo delay lines, answer prompt or slow
  always @(posedge aclk) begin
    cts_pipe <= {cts_pipe[14:0], request_to_send_low};
    dsr_pipe <= {dsr_pipe[14:0], terminal_ready_low};
  end
  // Pin outputs; serial line looped back at the far end
  assign clear_to_send_low_in = cts_pipe[delay];
  assign data_set_ready_low_in = dsr_pipe[delay];
  assign ring_indicator_low_in = ring_carrier_low[1];
  assign carrier_detect_low_in = ring_carrier_low[0];
  assign serial_in = serial_out;
endmodule // modem_partner

// >>> test/testbench.sv
// Self-checking bench of the modem control block with a modem model.
// Assumes the register map header is on the include path.
`timescale 1ns/10ps
`include "uart_modem_map.vh"
module testbench;
  logic aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, fifo_enable, tx_serial_data, rx_serial_data;
  logic ir_mode_enable, auto_flow_active, loopback_active, serial_in, serial_out;
  logic terminal_ready_low, request_to_send_low, user_output_one_low, user_output_two_low;
  logic clear_to_send_low_in, data_set_ready_low_in, ring_indicator_low_in;
  logic carrier_detect_low_in, clear_to_send_status_low, data_set_ready_status_low;
  logic ring_indicator_status_low, carrier_detect_status_low;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb, delay;
  logic [1:0] bresp, rresp, receive_trigger_level, ring_carrier_low, resp;
  logic [4:0] rx_fifo_count;
  integer n_mismatch, num_checks, i;
  // Rows: data[19:12], trigger[11:10], fill[9:5], pins {out2,out1,send,ready}[3:0]
  logic [19:0] rows [15] = '{20'h0000f, 20'h0100e, 20'h0200d, 20'h0400b, 20'h08007,
    20'h0f000, 20'h1f00f, 20'h2202d, 20'h2204f, 20'h2248d, 20'h224af, 20'h2290d,
    20'h2292f, 20'h22dcd, 20'h22def};
  wire [3:0] pins = {user_output_two_low, user_output_one_low, request_to_send_low,
    terminal_ready_low};
  wire [3:0] stat = {carrier_detect_status_low, ring_indicator_status_low,
    data_set_ready_status_low, clear_to_send_status_low};

  uart_modem_control uut (.*);
  modem_partner modem (.*);

  // Clock of 25 ns
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end

  task tally_and_finish;
    begin
      if (n_mismatch == 0 && num_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks++;
      if (seen !== exp) begin
        n_mismatch++;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Bus write: address and data offered together, response awaited
  task wr(input [7:0] a, input [31:0] d);
    logic ta, tw, tb;
    int k;
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      for (k = 0; k < 30; k++) begin
        @(negedge aclk);
        ta = awvalid && awready;
        tw = wvalid && wready;
        tb = bvalid && bready;
        resp = bresp;
        @(posedge aclk);
        if (!awvalid && !wvalid) bready <= 1;
        if (ta) awvalid <= 0;
        if (tw) wvalid <= 0;
        if (tb) begin
          bready <= 0;
          return;
        end
      end
      n_mismatch++;
      tally_and_finish;
    end
  endtask

  // Bus read, ready raised late to exercise holding
  task rd(input [7:0] a);
    logic ta, tr;
    int k;
    begin
      araddr <= a;
      arvalid <= 1;
      for (k = 0; k < 30; k++) begin
        @(negedge aclk);
        ta = arvalid && arready;
        tr = rvalid && rready;
        rd_val = rdata;
        resp = rresp;
        @(posedge aclk);
        if (!arvalid) rready <= 1;
        if (ta) arvalid <= 0;
        if (tr) begin
          rready <= 0;
          return;
        end
      end
      n_mismatch++;
      tally_and_finish;
    end
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {clk_en, fifo_enable, tx_serial_data, wstrb, ring_carrier_low} = '1;
    {receive_trigger_level, rx_fifo_count, delay} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(8'h10);
    chk(rd_val, 0);
    chk(pins, 4'hf);
    for (i = 0; i < 15; i++) begin
      receive_trigger_level <= rows[i][11:10];
      rx_fifo_count <= rows[i][9:5];
      wr(8'h10, 32'hffffffc0 | rows[i][19:12]);
      rd(8'h10);
      chk(rd_val, rows[i][19:12]);
      chk(pins, rows[i][3:0]);
      chk(auto_flow_active, rows[i][17]);
    end
    fifo_enable <= 0;
    rx_fifo_count <= 5'd20;
    rd(8'h10);
    chk(pins, 4'hd);
    fifo_enable <= 1;
    receive_trigger_level <= 0;
    rx_fifo_count <= 5'd14;
    wr(8'h40, 1);
    rd(8'h40);
    chk(rd_val, 1);
    chk(pins, 4'hd);
    rx_fifo_count <= 5'd15;
    rd(8'h10);
    chk(pins, 4'hf);
    wr(8'h40, 3);
    wr(8'h10, 32'h40);
    chk(ir_mode_enable, 1);
    wr(8'h40, 0);
    wr(8'h10, 0);
    rd(8'h10);
    chk(rd_val, 32'h40);
    wr(8'h40, 2);
    ring_carrier_low <= 2'b00;
    tx_serial_data <= 0;
    wr(8'h10, 32'h15);
    @(negedge aclk);
    chk(stat, 4'h9);
    chk(pins, 4'hf);
    chk(rx_serial_data, 0);
    chk(serial_out, 1);
    chk(loopback_active, 1);
    @(posedge aclk);
    rd(8'h18);
    chk(rd_val, 32'h16);
    tx_serial_data <= 1;
    delay <= 4'd5;
    ring_carrier_low <= 2'b01;
    wr(8'h10, 3);
    repeat (14) @(posedge aclk);
    rd(8'h20);
    chk(resp, `RESP_SLVERR);
    chk(rd_val, 0);
    chk(stat, 4'h8);
    wr(8'h18, 32'h7f);
    chk(resp, `RESP_OKAY);
    wr(8'h20, 1);
    chk(resp, `RESP_SLVERR);
    rd(8'h18);
    chk(rd_val, 32'h47);
    // Clock enable low freezes the serial path
    clk_en <= 0;
    tx_serial_data <= 0;
    repeat (3) @(negedge aclk);
    chk(serial_out, 1);
    chk(pins, 4'hc);
    @(posedge aclk);
    clk_en <= 1;
    repeat (8) @(negedge aclk);
    chk(serial_out, 0);
    chk(rx_serial_data, 0);
    @(posedge aclk);
    aresetn <= 0;
    @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(8'h10);
    chk(rd_val, 0);
    chk(pins, 4'hf);
    tally_and_finish;
  end
endmodule // testbench

// >>> test/uart_modem_control_assertions.sv
// Checker of the modem control block, bound to its top module ports.
// Assumes one clock, aclk, and a synchronous active-low reset.
`timescale 1ns/10ps
module modem_control_checker #(
  parameter FIFO_DEPTH = 16,
  parameter CNT_W = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire rready,
  input wire fifo_enable,
  input wire [CNT_W-1:0] rx_fifo_count,
  input wire tx_serial_data,
  input wire rx_serial_data,
  input wire ir_mode_enable,
  input wire auto_flow_active,
  input wire loopback_active,
  input wire serial_out,
  input wire terminal_ready_low,
  input wire request_to_send_low,
  input wire user_output_one_low,
  input wire user_output_two_low,
  input wire data_set_ready_low_in,
  input wire data_set_ready_status_low
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both halves of a write taken at one edge
  sequence s_write_taken;
    awvalid && awready && wvalid && wready && clk_en;
  endsequence
  // Ready pin held still for seven running cycles outside loopback
  sequence s_ready_still;
    (!loopback_active && clk_en && $stable(data_set_ready_low_in)) [*7];
  endsequence
  a_write_answer: assert property (s_write_taken |-> ##[1:3] bvalid)
    else $error("write response missing");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_reset_state: assert property (disable iff (1'b0) !aresetn |=>
    !loopback_active && !auto_flow_active && !ir_mode_enable && serial_out)
    else $error("reset state wrong");
  a_loop_pins: assert property (loopback_active && clk_en |=> {user_output_two_low,
    user_output_one_low, request_to_send_low, terminal_ready_low} == 4'hf)
    else $error("handshake pin active in loopback");
  a_serial_loop: assert property (loopback_active && !ir_mode_enable && clk_en |=>
    serial_out && rx_serial_data == $past(tx_serial_data))
    else $error("serial loop wrong");
  a_rts_gated: assert property (auto_flow_active && fifo_enable && !loopback_active &&
    clk_en && rx_fifo_count > FIFO_DEPTH - 2 |=> request_to_send_low)
    else $error("send request not gated");
  a_status_ext: assert property (s_ready_still |->
    data_set_ready_status_low == data_set_ready_low_in)
    else $error("ready status does not follow pin");
  a_freeze_hold: assert property (!clk_en |=> $stable({serial_out, rx_serial_data, bvalid,
    terminal_ready_low, request_to_send_low, user_output_one_low, user_output_two_low}))
    else $error("state moved while clock enable low");
endmodule // modem_control_checker

bind uart_modem_control modem_control_checker #(.FIFO_DEPTH(FIFO_DEPTH), .CNT_W(CNT_W)) u_chk (
  .aclk, .aresetn, .clk_en, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .rdata, .rvalid, .rready, .fifo_enable, .rx_fifo_count, .tx_serial_data,
  .rx_serial_data, .ir_mode_enable, .auto_flow_active, .loopback_active, .serial_out,
  .terminal_ready_low, .request_to_send_low, .user_output_one_low, .user_output_two_low,
  .data_set_ready_low_in, .data_set_ready_status_low
);
